// ===== rxof_formatter.sv
// Receive output formatter: recovered clock and rail outputs for one channel
`timescale 1ns/1ps
`default_nettype none
`include "rxof_regs.svh"
module rxof_formatter
    import rxof_pkg::*;
#(
    parameter int WORD_W     = `RXOF_WORD_W,
    parameter int FIFO_DEPTH = `RXOF_FIFO_DEPTH
)
(
    input  wire logic                              clk_sys,
    input  wire logic                              rst,
    input  wire logic                              recClkIn,
    input  wire logic                              posPulseIn,
    input  wire logic                              negPulseIn,
    input  wire logic                              lineCodeViolation,
    input  wire logic                              excessZeroEvent,
    input  wire logic                              singleRailSel,
    input  wire logic                              fallingEdgeSel,
    output logic                                   recoveredClkOut,
    output logic                                   posRailOut,
    output logic                                   negRailOut,
    output logic                                   sampleDropped,
    output logic                                   launchUnderrun,
    output logic [$clog2(FIFO_DEPTH+1)-1:0]        fifoLevel
);
    localparam int LW = $clog2(FIFO_DEPTH+1);

    // Two-stage synchronisers for every pin-level input
    logic [`RXOF_SYNC_STAGES-1:0] clkSync_reg;
    logic [`RXOF_SYNC_STAGES-1:0] posSync_reg;
    logic [`RXOF_SYNC_STAGES-1:0] negSync_reg;
    logic [`RXOF_SYNC_STAGES-1:0] violSync_reg;
    logic [`RXOF_SYNC_STAGES-1:0] zeroSync_reg;
    logic [`RXOF_SYNC_STAGES-1:0] modeSync_reg;
    logic [`RXOF_SYNC_STAGES-1:0] edgeSync_reg;
    logic [`RXOF_SYNC_STAGES:0]   warm_reg;

    logic                 clkLast_reg;
    logic                 clkRise;
    logic                 clkFall;
    logic                 launchEdge;
    logic                 recClkOut_reg;
    logic                 posRail_reg;
    logic                 negRail_reg;
    logic                 posRail_next;
    logic                 negRail_next;
    logic                 dropped_reg;
    logic                 underrun_reg;
    logic [LW-1:0]        level_reg;
    rxof_mode_t           mode_reg;
    rxof_state_t          state_reg;
    rxof_state_t          state_next;
    logic                 fallSel_reg;

    logic [WORD_W-1:0]    sampleWord;
    logic                 fifoInReady;
    logic                 fifoOutValid;
    logic                 fifoPop;
    logic [WORD_W-1:0]    fifoOutData;
    logic [LW-1:0]        fifoCount;

    // Positive rail content of a stored word for the given mode
    function automatic logic railPos(input logic [WORD_W-1:0] w, input rxof_mode_t m);
        logic r;
        r = 1'b0;
        if (m == RXOF_MODE_SINGLE)
        begin
            // Either polarity is a recovered one in single-rail
            r = w[`RXOF_F_POS] | w[`RXOF_F_NEG];
        end
        else
        begin
            r = w[`RXOF_F_POS];
        end
        return r;
    endfunction

    // Negative rail content of a stored word for the given mode
    function automatic logic railNeg(input logic [WORD_W-1:0] w, input rxof_mode_t m);
        logic r;
        r = 1'b0;
        if (m == RXOF_MODE_SINGLE)
        begin
            r = w[`RXOF_F_VIOL] | w[`RXOF_F_ZERO];
        end
        else
        begin
            r = w[`RXOF_F_NEG];
        end
        return r;
    endfunction

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            clkSync_reg  <= '0;
            posSync_reg  <= '0;
            negSync_reg  <= '0;
            violSync_reg <= '0;
            zeroSync_reg <= '0;
            modeSync_reg <= '0;
            edgeSync_reg <= '0;
        end
        else
        begin
            clkSync_reg  <= {clkSync_reg[0], recClkIn};
            posSync_reg  <= {posSync_reg[0], posPulseIn};
            negSync_reg  <= {negSync_reg[0], negPulseIn};
            violSync_reg <= {violSync_reg[0], lineCodeViolation};
            zeroSync_reg <= {zeroSync_reg[0], excessZeroEvent};
            modeSync_reg <= {modeSync_reg[0], singleRailSel};
            edgeSync_reg <= {edgeSync_reg[0], fallingEdgeSel};
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            clkLast_reg <= `RXOF_CLK_RESET;
        end
        else
        begin
            clkLast_reg <= clkSync_reg[1];
        end
    end

    // Edge detect waits for the chain to refill, else a reset fakes an edge
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            warm_reg <= '0;
        end
        else
        begin
            warm_reg <= {warm_reg[`RXOF_SYNC_STAGES-1:0], 1'b1};
        end
    end

    assign clkRise = warm_reg[`RXOF_SYNC_STAGES] && clkSync_reg[1] && !clkLast_reg;
    assign clkFall = warm_reg[`RXOF_SYNC_STAGES] && !clkSync_reg[1] && clkLast_reg;

    // Selected edge of the outgoing clock; output clock follows the sync stage
    assign launchEdge = fallSel_reg ? clkFall : clkRise;

    // Configuration is taken at a launch, and on every cycle while in RXOF_ST_PRIME
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            mode_reg    <= RXOF_MODE_DUAL;
            fallSel_reg <= 1'b0;
        end
        else if (launchEdge || state_reg == RXOF_ST_PRIME)
        begin
            mode_reg    <= modeSync_reg[1] ? RXOF_MODE_SINGLE : RXOF_MODE_DUAL;
            fallSel_reg <= edgeSync_reg[1];
        end
    end

    // Line data is stable at the rising recovered edge
    always_comb
    begin
        sampleWord = '0;
        sampleWord[`RXOF_F_POS] = posSync_reg[1];
        sampleWord[`RXOF_F_NEG] = negSync_reg[1];
        sampleWord[`RXOF_F_VIOL] = violSync_reg[1];
        sampleWord[`RXOF_F_ZERO] = zeroSync_reg[1];
    end

    rxof_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .inValid  (clkRise),
        .inReady  (fifoInReady),
        .inData   (sampleWord),
        .outValid (fifoOutValid),
        .outReady (fifoPop),
        .outData  (fifoOutData),
        .level    (fifoCount)
    );

    // Priming leaves slack against small drift between sample and launch edges
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            RXOF_ST_PRIME:
            begin
                if (fifoCount >= LW'(`RXOF_PRIME_LEVEL))
                begin
                    state_next = RXOF_ST_RUN;
                end
            end
            RXOF_ST_RUN:
            begin
                if (launchEdge && !fifoOutValid)
                begin
                    state_next = RXOF_ST_PRIME;
                end
            end
            default:
            begin
                state_next = RXOF_ST_PRIME;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_reg <= RXOF_ST_PRIME;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign fifoPop = launchEdge && (state_reg == RXOF_ST_RUN);

    // Rails hold between launches; an empty FIFO launches zeros
    always_comb
    begin
        posRail_next = posRail_reg;
        negRail_next = negRail_reg;
        if (launchEdge)
        begin
            if (fifoPop && fifoOutValid)
            begin
                posRail_next = railPos(fifoOutData, mode_reg);
                negRail_next = railNeg(fifoOutData, mode_reg);
            end
            else
            begin
                posRail_next = `RXOF_RAIL_RESET;
                negRail_next = `RXOF_RAIL_RESET;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            posRail_reg <= `RXOF_RAIL_RESET;
            negRail_reg <= `RXOF_RAIL_RESET;
        end
        else
        begin
            posRail_reg <= posRail_next;
            negRail_reg <= negRail_next;
        end
    end

    // Same delay as the rails, so the rails move on the chosen clock edge
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            recClkOut_reg <= `RXOF_CLK_RESET;
        end
        else
        begin
            recClkOut_reg <= clkSync_reg[1];
        end
    end

    // Status: full FIFO drops a sample, empty FIFO at a launch in RXOF_ST_RUN is an underrun
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            dropped_reg  <= 1'b0;
            underrun_reg <= 1'b0;
        end
        else
        begin
            dropped_reg  <= clkRise && !fifoInReady;
            underrun_reg <= launchEdge && (state_reg == RXOF_ST_RUN) && !fifoOutValid;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            level_reg <= '0;
        end
        else
        begin
            level_reg <= fifoCount;
        end
    end

    assign recoveredClkOut = recClkOut_reg;
    assign posRailOut      = posRail_reg;
    assign negRailOut      = negRail_reg;
    assign sampleDropped   = dropped_reg;
    assign launchUnderrun  = underrun_reg;
    assign fifoLevel       = level_reg;
endmodule
`default_nettype wire

// ===== rxof_regs.svh
// Constants for the receive output formatter: field positions, depths, reset values
// Notes on behaviour
// - Dual-rail: every negative line pulse appears on the negative rail, apart from positive.
// - Dual-rail: positive received data goes only to the positive rail of this channel.
// - Dual-rail: each negative pulse drives the negative rail high one recovered period.
// - Single-rail: negative rail carries the code-violation indicator instead of data.
// - Single-rail: violation or excess-zero event holds the indicator high at least one period.
// - Recovered clock is output; both rails launch on its user-selected edge.
// - Single-rail: violation indicator also updates on the selected recovered clock edge.
// - Negative rail changes only on the chosen edge of the recovered clock, either mode.
// - Dual-rail: each positive pulse drives the positive rail high one recovered period.
// - Single-rail: all recovered data is delivered on the positive rail.
`ifndef RXOF_REGS_SVH
`define RXOF_REGS_SVH

`define RXOF_WORD_W        4
`define RXOF_FIFO_DEPTH    4
`define RXOF_F_POS         0
`define RXOF_F_NEG         1
`define RXOF_F_VIOL        2
`define RXOF_F_ZERO        3
`define RXOF_PRIME_LEVEL   3'h2
`define RXOF_RAIL_RESET    1'b0
`define RXOF_CLK_RESET     1'b0
`define RXOF_SYNC_STAGES   2

`endif

// ===== rxof_pkg.sv
// Types shared by the receive output formatter
package rxof_pkg;
    typedef enum logic [1:0] {
        RXOF_ST_PRIME = 2'b01,
        RXOF_ST_RUN   = 2'b10
    } rxof_state_t;

    typedef enum logic [1:0] {
        RXOF_MODE_DUAL   = 2'b01,
        RXOF_MODE_SINGLE = 2'b10
    } rxof_mode_t;
endpackage

// ===== rxof_fifo.sv
// Small synchronous FIFO between line sampling and output launch
`timescale 1ns/1ps
`default_nettype none
module rxof_fifo
    import rxof_pkg::*;
#(
    parameter int WIDTH = 4,
    parameter int DEPTH = 4
)
(
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    input  wire logic                     inValid,
    output logic                          inReady,
    input  wire logic [WIDTH-1:0]         inData,
    output logic                          outValid,
    input  wire logic                     outReady,
    output logic [WIDTH-1:0]              outData,
    output logic [$clog2(DEPTH+1)-1:0]    level
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_reg;
    logic [AW-1:0]    rdPtr_reg;
    logic [CW-1:0]    count_reg;
    logic             doPush;
    logic             doPop;

    assign inReady  = (count_reg != CW'(DEPTH));
    assign outValid = (count_reg != '0);
    assign outData  = mem[rdPtr_reg];
    assign level    = count_reg;
    assign doPush   = inValid && inReady;
    assign doPop    = outValid && outReady;

    always_ff @(posedge clk_sys)
    begin
        if (doPush)
        begin
            mem[wrPtr_reg] <= inData;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
        end
        else
        begin
            if (doPush)
            begin
                wrPtr_reg <= (wrPtr_reg == AW'(DEPTH-1)) ? '0 : AW'(wrPtr_reg + 1'b1);
            end
            if (doPop)
            begin
                rdPtr_reg <= (rdPtr_reg == AW'(DEPTH-1)) ? '0 : AW'(rdPtr_reg + 1'b1);
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            count_reg <= '0;
        end
        else if (doPush && !doPop)
        begin
            count_reg <= CW'(count_reg + 1'b1);
        end
        else if (doPop && !doPush)
        begin
            count_reg <= CW'(count_reg - 1'b1);
        end
    end
endmodule
`default_nettype wire

// ===== rxof_formatter_monitor.sv
// Port-level checks for the receive output formatter
`timescale 1ns/1ps
`default_nettype none
module rxof_formatter_monitor
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic recClkIn,
    input wire logic singleRailSel,
    input wire logic fallingEdgeSel,
    input wire logic recoveredClkOut,
    input wire logic posRailOut,
    input wire logic negRailOut
);
    logic [1:0] selPrev_reg;
    logic [4:0] selAge_reg;
    wire        selSettled = selAge_reg == 5'h1f;

    // Launch edge may follow the old select for a few cycles
    always_ff @(posedge clk_sys)
    begin
        selPrev_reg <= {singleRailSel, fallingEdgeSel};
        if (rst || selPrev_reg != {singleRailSel, fallingEdgeSel})
            selAge_reg <= 5'h00;
        else if (!selSettled)
            selAge_reg <= selAge_reg + 5'h01;
    end

    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    clk_follow_a: assert property ($rose(recClkIn) |-> ##[2:4] $rose(recoveredClkOut))
        else $error("recovered clock lost");
    pos_launch_a: assert property (selSettled && $changed(posRailOut)
        |-> $changed(recoveredClkOut) && recoveredClkOut == !fallingEdgeSel)
        else $error("positive rail off launch edge");
    flag_launch_a: assert property (selSettled && singleRailSel && $changed(negRailOut)
        |-> $changed(recoveredClkOut) && recoveredClkOut == !fallingEdgeSel)
        else $error("flag off launch edge");
    neg_edge_a: assert property ($changed(negRailOut) |-> $changed(recoveredClkOut))
        else $error("negative rail off clock edge");
    neg_hold_a: assert property (selSettled && !singleRailSel && $rose(negRailOut)
        |-> negRailOut[*8])
        else $error("negative pulse too short");
    pos_hold_a: assert property (selSettled && !singleRailSel && $rose(posRailOut)
        |-> posRailOut[*8])
        else $error("positive pulse too short");
    flag_hold_a: assert property (selSettled && singleRailSel && $rose(negRailOut)
        |-> negRailOut[*8])
        else $error("flag pulse too short");
    rails_apart_a: assert property (selSettled && !singleRailSel |-> !(posRailOut && negRailOut))
        else $error("both rails high");
    quiet_start_a: assert property ($fell(rst) |-> !posRailOut && !negRailOut && !recoveredClkOut)
        else $error("outputs active after reset");
endmodule

bind rxof_formatter rxof_formatter_monitor i_mon
(
    .clk_sys(clk_sys),
    .rst(rst),
    .recClkIn(recClkIn),
    .singleRailSel(singleRailSel),
    .fallingEdgeSel(fallingEdgeSel),
    .recoveredClkOut(recoveredClkOut),
    .posRailOut(posRailOut),
    .negRailOut(negRailOut)
);
`default_nettype wire

// ===== rxof_term_model.sv
// Terminal-side receiver model capturing the rails mid-period
`timescale 1ns/1ps
`default_nettype none
module rxof_term_model
(
    input  wire logic       clk_sys,
    input  wire logic       fallingEdgeSel,
    input  wire logic       recoveredClkOut,
    input  wire logic       posRailOut,
    input  wire logic       negRailOut,
    output logic            gotValid,
    output logic [1:0]      gotRails
);
    logic clkPrev_reg;

    // Capture on the edge opposite launch; idle words are not reported
    always_ff @(posedge clk_sys)
    begin
        clkPrev_reg <= recoveredClkOut;
        gotValid    <= clkPrev_reg != recoveredClkOut && recoveredClkOut == fallingEdgeSel
                       && (posRailOut || negRailOut);
        gotRails    <= {negRailOut, posRailOut};
    end
endmodule
`default_nettype wire

// ===== rxof_formatter_tb.sv
// Self-checking bench for the receive output formatter
`timescale 1ns/1ps
`default_nettype none
`include "rxof_regs.svh"
module rxof_formatter_tb;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic       recClkIn = 1'b0;
    logic [3:0] lineWord = 4'h0;
    logic       singleRailSel = 1'b0;
    logic       fallingEdgeSel = 1'b0;
    logic       recoveredClkOut;
    logic       posRailOut;
    logic       negRailOut;
    logic [2:0] fifoLevel;
    logic [2:0] peakLevel = 3'h0;
    logic       sampleDropped;
    logic       launchUnderrun;
    logic [7:0] nDropped = 8'h00;
    logic [7:0] nUnderrun = 8'h00;
    logic       gotValid;
    logic [1:0] gotRails;
    logic [1:0] expQ[$];
    logic [7:0] lfsr = 8'h12;
    int         n_fail = 0;
    int         n_checks = 0;
    int         cycles = 0;

    always #25 clk_sys = ~clk_sys;

    rxof_formatter i_dut (.clk_sys(clk_sys), .rst(rst), .recClkIn(recClkIn),
        .posPulseIn(lineWord[0]), .negPulseIn(lineWord[1]),
        .lineCodeViolation(lineWord[2]), .excessZeroEvent(lineWord[3]),
        .singleRailSel(singleRailSel), .fallingEdgeSel(fallingEdgeSel),
        .recoveredClkOut(recoveredClkOut), .posRailOut(posRailOut),
        .negRailOut(negRailOut), .sampleDropped(sampleDropped),
        .launchUnderrun(launchUnderrun),
        .fifoLevel(fifoLevel));

    rxof_term_model i_term (.clk_sys(clk_sys), .fallingEdgeSel(fallingEdgeSel),
        .recoveredClkOut(recoveredClkOut), .posRailOut(posRailOut),
        .negRailOut(negRailOut), .gotValid(gotValid), .gotRails(gotRails));

    function automatic logic [7:0] lfsrNext(input logic [7:0] v);
        lfsrNext = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic checkRails(input logic [1:0] expV, input logic [1:0] gotV);
        n_checks++;
        if (gotV !== expV)
        begin
            n_fail++;
            $display("[FAIL] rails expected %b seen %b", expV, gotV);
        end
    endtask

    task automatic checkStatus(input string name, input logic [7:0] expV,
                               input logic [7:0] gotV);
        n_checks++;
        if (gotV !== expV)
        begin
            n_fail++;
            $display("[FAIL] %s expected %0d seen %0d", name, expV, gotV);
        end
    endtask

    // One recovered period; data moves at the input clock's fall
    task automatic sendWord(input logic [3:0] w);
        logic [1:0] e;
        @(posedge clk_sys);
        recClkIn <= 1'b0;
        lineWord <= w;
        tick(4);
        recClkIn <= 1'b1;
        e = singleRailSel ? {w[3] | w[2], w[1] | w[0]} : w[1:0];
        if (e != 2'b00)
            expQ.push_back(e);
        tick(3);
    endtask

    always @(posedge clk_sys)
    begin
        if (gotValid === 1'b1)
        begin
            if (expQ.size() == 0)
                checkRails(2'b00, gotRails);
            else
                checkRails(expQ.pop_front(), gotRails);
        end
    end

    // Equal sample and launch rates: no loss, no underrun, FIFO peaks at priming level
    always @(posedge clk_sys)
    begin
        if (rst === 1'b0)
        begin
            if (sampleDropped !== 1'b0)
                nDropped++;
            if (launchUnderrun !== 1'b0)
                nUnderrun++;
            if (fifoLevel > peakLevel)
                peakLevel = fifoLevel;
        end
    end

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_fail++;
            end_of_test();
        end
    end

    // Every mode and edge pair; idle words flush the data words out of the FIFO before a switch
    initial
    begin
        tick(10);
        rst <= 1'b0;
        for (int m = 0; m < 4; m++)
        begin
            if (m == 2)
            begin
                rst <= 1'b1;
                tick(4);
                rst <= 1'b0;
            end
            tick(1);
            singleRailSel  <= m[0];
            fallingEdgeSel <= m[1];
            repeat (4) sendWord(4'h0);
            for (int i = 0; i < 24; i++)
            begin
                lfsr = lfsrNext(lfsr);
                sendWord({lfsr[4] & lfsr[3], lfsr[2], lfsr[1] & ~lfsr[0], lfsr[0]});
            end
            repeat (6) sendWord(4'h0);
        end
        checkStatus("dropped", 8'h00, nDropped);
        checkStatus("underrun", 8'h00, nUnderrun);
        checkStatus("peak level", 8'(`RXOF_PRIME_LEVEL), {5'h00, peakLevel});
        n_checks++;
        if (expQ.size() != 0)
        begin
            n_fail++;
            $display("[FAIL] pending expected 0 seen %0d", expQ.size());
        end
        end_of_test();
    end
endmodule
`default_nettype wire
